/* File: floppy_cmd_map.svh */
// Opcodes, result lengths, reset values and field positions for the command subset decoder.
`ifndef FLOPPY_CMD_MAP_SVH
`define FLOPPY_CMD_MAP_SVH

// -----------------------------------------------------------------------------
// Opcode matching
// -----------------------------------------------------------------------------
`define FCS_OP_DUMP 8'h0e
`define FCS_OP_READID 8'h0a
`define FCS_OP_READID_MASK 8'hbf
`define FCS_OP_PERP 8'h12
`define FCS_OP_LOCK 8'h14
`define FCS_OP_LOCK_MASK 8'h7f
// One bit per low-five-bit code that another command handler owns.
`define FCS_OTHER_CODES 32'h234bb3fc

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define FCS_DD_BIT 6
`define FCS_HEAD_BIT 2
`define FCS_LOCK_OP_BIT 7
`define FCS_OVERWRITE_BIT 7

// -----------------------------------------------------------------------------
// Result lengths (index of the last byte) and fixed answers
// -----------------------------------------------------------------------------
`define FCS_DUMP_LAST 4'h9
`define FCS_RID_LAST 4'h6
`define FCS_ONE_LAST 4'h0
`define FCS_INVALID_STATUS 8'h80

// -----------------------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------------------
`define FCS_CFG_RESET 15'h2000
`define FCS_PERP_RESET 6'h00

`endif

/* File: floppy_cmd_pkg.sv */
// Types shared by the floppy command subset decoder.
package floppy_cmd_pkg;

	// -------------------------------------------------------------------------
	// Sequencer states, Gray coded along idle, param, exec, result.
	// -------------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PARAM = 2'b01,
		ST_EXEC = 2'b11,
		ST_RESULT = 2'b10
	} state_t;

	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_DUMP,
		CMD_READID,
		CMD_PERP,
		CMD_LOCK,
		CMD_INVALID
	} cmd_t;

	// -------------------------------------------------------------------------
	// Carried parameter groups.
	// -------------------------------------------------------------------------
	typedef struct packed {
		logic implied_seek_enable;
		logic queue_disable;
		logic poll_disable;
		logic [3:0] queue_threshold;
		logic [7:0] precompensation_start_track;
	} config_t;

	typedef struct packed {
		logic [3:0] perpDrives;
		logic gap;
		logic write_gate_timing;
	} perp_t;

	typedef struct packed {
		logic [3:0] step_rate_time;
		logic [3:0] head_unload_time;
		logic [6:0] head_load_time;
		logic non_dma_flag;
	} specify_t;

	typedef struct packed {
		logic [7:0] status_zero;
		logic [7:0] status_one;
		logic [7:0] status_two;
		logic [7:0] cylinder;
		logic [7:0] head;
		logic [7:0] sector;
		logic [7:0] sizeCode;
	} id_result_t;

endpackage : floppy_cmd_pkg

/* File: floppy_result_mux.sv */
// Result byte selector for the command subset decoder.
`include "floppy_cmd_map.svh"

module floppy_result_mux import floppy_cmd_pkg::*; (
	input wire cmd_t kind,
	input wire logic [3:0] index,
	input wire logic [3:0][7:0] present_cylinder_number,
	input wire specify_t spec,
	input wire logic [7:0] sharedCount,
	input wire logic retention,
	input wire perp_t perp,
	input wire config_t cfg,
	input wire id_result_t idRes,
	output logic [7:0] byteOut,
	output logic [3:0] lastIndex
);

	// -------------------------------------------------------------------------
	// Byte selection by command and position.
	// -------------------------------------------------------------------------
	// Pure selection; the caller registers the byte so the pin stays glitch free.
	always_comb begin
		byteOut = 8'h00;
		lastIndex = `FCS_ONE_LAST;
		unique case (kind)
			CMD_DUMP: begin
				lastIndex = `FCS_DUMP_LAST;
				unique case (index)
					4'h0, 4'h1, 4'h2, 4'h3: byteOut = present_cylinder_number[index[1:0]];
					4'h4: byteOut = {spec.step_rate_time, spec.head_unload_time};
					4'h5: byteOut = {spec.head_load_time, spec.non_dma_flag};
					4'h6: byteOut = sharedCount;
					4'h7: byteOut = {retention, 1'b0, perp};
					4'h8: byteOut = {1'b0, cfg.implied_seek_enable, cfg.queue_disable,
						cfg.poll_disable, cfg.queue_threshold};
					default: byteOut = cfg.precompensation_start_track;
				endcase
			end
			CMD_READID: begin
				lastIndex = `FCS_RID_LAST;
				unique case (index)
					4'h0: byteOut = idRes.status_zero;
					4'h1: byteOut = idRes.status_one;
					4'h2: byteOut = idRes.status_two;
					4'h3: byteOut = idRes.cylinder;
					4'h4: byteOut = idRes.head;
					4'h5: byteOut = idRes.sector;
					default: byteOut = idRes.sizeCode;
				endcase
			end
			CMD_LOCK: byteOut = {3'b000, retention, 4'h0};
			CMD_INVALID: byteOut = `FCS_INVALID_STATUS;
			default: byteOut = 8'h00;
		endcase
	end

endmodule : floppy_result_mux

/* File: floppy_command_subset_decoder.sv */
// Command, execution and result sequencer for the dump, read-identifier, perpendicular and lock set.
`include "floppy_cmd_map.svh"

module floppy_command_subset_decoder import floppy_cmd_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdByte,
	input wire logic resultRead,
	input wire logic softReset,
	input wire logic cfgLoad,
	input wire config_t cfgIn,
	input wire specify_t specIn,
	input wire logic [3:0][7:0] present_cylinder_number,
	input wire logic lastWasFormat,
	input wire logic [7:0] sectors_per_cylinder,
	input wire logic [7:0] final_sector_number,
	input wire logic idFound,
	input wire id_result_t idIn,
	input wire logic [1:0] digital_output_register_drive,
	output logic resultReady,
	output logic [7:0] resultByte,
	output logic busy,
	output logic readIdStart,
	output logic double_density_select,
	output logic head_select,
	output logic [1:0] cmdDrive,
	output logic standby,
	output logic handOff,
	output logic [7:0] handOffOpcode,
	output logic retentionFlag,
	output perp_t perpOut,
	output config_t cfgOut,
	output logic [1:0] driveSelectPin
);

	// -------------------------------------------------------------------------
	// State.
	// -------------------------------------------------------------------------
	state_t state_reg, state_next;
	cmd_t kind_reg, kind_next;
	logic [3:0] idx_reg, idx_next;
	logic [7:0] resultByte_reg, resultByte_next;
	logic resultReady_reg, resultReady_next;
	logic busy_reg, busy_next;
	logic readIdStart_reg, readIdStart_next;
	logic dd_reg, dd_next;
	logic head_reg, head_next;
	logic [1:0] drive_reg, drive_next;
	logic standby_reg, standby_next;
	logic handOff_reg, handOff_next;
	logic [7:0] opcode_reg, opcode_next;
	logic lock_reg, lock_next;
	perp_t perp_reg, perp_next;
	config_t cfg_reg, cfg_next;
	id_result_t id_reg, id_next;
	logic [1:0] drvPin_reg, drvPin_next;
	logic [7:0] muxByte, sharedCount;
	logic [3:0] lastIdx;
	logic isOther;

	// Side paths stay out of the sequencer process, so the byte selector forms no loop with it.
	assign sharedCount = lastWasFormat ? sectors_per_cylinder : final_sector_number;
	assign isOther = 1'(`FCS_OTHER_CODES >> cmdByte[4:0]);
	assign lastIdx = (kind_reg == CMD_DUMP) ? `FCS_DUMP_LAST
		: (kind_reg == CMD_READID) ? `FCS_RID_LAST : `FCS_ONE_LAST;
	assign resultByte_next = resultReady_next ? muxByte : 8'h00;

	// -------------------------------------------------------------------------
	// Result byte source, fed with next values so the byte lines up with state.
	// -------------------------------------------------------------------------
	floppy_result_mux floppy_result_mux_inst (
		.kind(kind_next),
		.index(idx_next),
		.present_cylinder_number(present_cylinder_number),
		.spec(specIn),
		.sharedCount(sharedCount),
		.retention(lock_next),
		.perp(perp_next),
		.cfg(cfg_next),
		.idRes(id_next),
		.byteOut(muxByte),
		.lastIndex()
	);

	// Sequencer and parameter store next values.
	always_comb begin
		state_next = state_reg;
		kind_next = kind_reg;
		idx_next = idx_reg;
		dd_next = dd_reg;
		head_next = head_reg;
		drive_next = drive_reg;
		standby_next = standby_reg;
		opcode_next = opcode_reg;
		lock_next = lock_reg;
		perp_next = perp_reg;
		cfg_next = cfg_reg;
		id_next = id_reg;
		readIdStart_next = 1'b0;
		handOff_next = 1'b0;
		drvPin_next = digital_output_register_drive;
		if (cfgLoad) begin
			cfg_next = cfgIn;
		end
		// Retention only shields a software reset; a hardware reset reloads every register's reset value.
		if (softReset && !lock_reg) begin
			cfg_next = `FCS_CFG_RESET;
			perp_next = `FCS_PERP_RESET;
		end
		unique case (state_reg)
			ST_IDLE: begin
				if (cmdWrite) begin
					idx_next = 4'h0;
					standby_next = 1'b0;
					if (cmdByte == `FCS_OP_DUMP) begin
						kind_next = CMD_DUMP;
						state_next = ST_RESULT;
					end else if ((cmdByte & `FCS_OP_READID_MASK) == `FCS_OP_READID) begin
						kind_next = CMD_READID;
						dd_next = cmdByte[`FCS_DD_BIT];
						state_next = ST_PARAM;
					end else if (cmdByte == `FCS_OP_PERP) begin
						kind_next = CMD_PERP;
						state_next = ST_PARAM;
					end else if ((cmdByte & `FCS_OP_LOCK_MASK) == `FCS_OP_LOCK) begin
						kind_next = CMD_LOCK;
						lock_next = cmdByte[`FCS_LOCK_OP_BIT];
						state_next = ST_RESULT;
					end else if (isOther) begin
						kind_next = CMD_NONE;
						handOff_next = 1'b1;
						opcode_next = cmdByte;
					end else begin
						kind_next = CMD_INVALID;
						standby_next = 1'b1;
						state_next = ST_RESULT;
					end
				end
			end
			ST_PARAM: begin
				if (cmdWrite) begin
					if (kind_reg == CMD_READID) begin
						head_next = cmdByte[`FCS_HEAD_BIT];
						drive_next = cmdByte[1:0];
						readIdStart_next = 1'b1;
						state_next = ST_EXEC;
					end else begin
						perp_next.gap = cmdByte[1];
						perp_next.write_gate_timing = cmdByte[0];
						if (cmdByte[`FCS_OVERWRITE_BIT]) begin
							perp_next.perpDrives = cmdByte[5:2];
						end
						state_next = ST_IDLE;
					end
				end
			end
			ST_EXEC: begin
				// Only the first good identifier is kept; later ones find us gone.
				if (idFound) begin
					id_next = idIn;
					idx_next = 4'h0;
					state_next = ST_RESULT;
				end
			end
			ST_RESULT: begin
				if (resultRead) begin
					if (idx_reg == lastIdx) begin
						state_next = ST_IDLE;
					end else begin
						idx_next = idx_reg + 4'h1;
					end
				end
			end
		endcase
		busy_next = state_next != ST_IDLE;
		resultReady_next = state_next == ST_RESULT;
	end

	// Register stage; a low clock enable freezes all state.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			kind_reg <= CMD_NONE;
			idx_reg <= 4'h0;
			resultByte_reg <= 8'h00;
			resultReady_reg <= 1'b0;
			busy_reg <= 1'b0;
			readIdStart_reg <= 1'b0;
			dd_reg <= 1'b0;
			head_reg <= 1'b0;
			drive_reg <= 2'b00;
			standby_reg <= 1'b0;
			handOff_reg <= 1'b0;
			opcode_reg <= 8'h00;
			lock_reg <= 1'b0;
			perp_reg <= `FCS_PERP_RESET;
			cfg_reg <= `FCS_CFG_RESET;
			id_reg <= '0;
			drvPin_reg <= 2'b00;
		end else if (clkEn) begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			idx_reg <= idx_next;
			resultByte_reg <= resultByte_next;
			resultReady_reg <= resultReady_next;
			busy_reg <= busy_next;
			readIdStart_reg <= readIdStart_next;
			dd_reg <= dd_next;
			head_reg <= head_next;
			drive_reg <= drive_next;
			standby_reg <= standby_next;
			handOff_reg <= handOff_next;
			opcode_reg <= opcode_next;
			lock_reg <= lock_next;
			perp_reg <= perp_next;
			cfg_reg <= cfg_next;
			id_reg <= id_next;
			drvPin_reg <= drvPin_next;
		end
	end

	assign resultReady = resultReady_reg;
	assign resultByte = resultByte_reg;
	assign busy = busy_reg;
	assign readIdStart = readIdStart_reg;
	assign double_density_select = dd_reg;
	assign head_select = head_reg;
	assign cmdDrive = drive_reg;
	assign standby = standby_reg;
	assign handOff = handOff_reg;
	assign handOffOpcode = opcode_reg;
	assign retentionFlag = lock_reg;
	assign perpOut = perp_reg;
	assign cfgOut = cfg_reg;
	assign driveSelectPin = drvPin_reg;

	// -------------------------------------------------------------------------
	// Checks.
	// -------------------------------------------------------------------------
	chk_dump_no_exec: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_reg == ST_IDLE && clkEn && cmdWrite && cmdByte == `FCS_OP_DUMP)
		|=> (state_reg == ST_RESULT && idx_reg == 4'h0 && resultReady))
		else $error("dump did not go straight to results");
	chk_dump_sector_count: assert property (@(posedge mclk) disable iff (!rst_n)
		(resultReady && kind_reg == CMD_DUMP && idx_reg == 4'h6 && $past(clkEn)
		&& $past(lastWasFormat)) |-> resultByte == $past(sectors_per_cylinder))
		else $error("dump shared byte is not sectors per cylinder");
	chk_dump_final_sector: assert property (@(posedge mclk) disable iff (!rst_n)
		(resultReady && kind_reg == CMD_DUMP && idx_reg == 4'h6 && $past(clkEn)
		&& !$past(lastWasFormat)) |-> resultByte == $past(final_sector_number))
		else $error("dump shared byte is not final sector");
	chk_readid_param: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_reg == ST_PARAM && kind_reg == CMD_READID && clkEn && cmdWrite)
		|=> ((readIdStart && head_select == $past(cmdByte[2])
		&& cmdDrive == $past(cmdByte[1:0])) and (clkEn |=> !readIdStart)))
		else $error("read identifier parameter byte mishandled");
	chk_readid_length: assert property (@(posedge mclk) disable iff (!rst_n)
		(kind_reg == CMD_READID && resultReady && idx_reg == `FCS_RID_LAST && clkEn && resultRead)
		|=> !resultReady)
		else $error("read identifier result length wrong");
	chk_readid_cyl: assert property (@(posedge mclk) disable iff (!rst_n)
		(kind_reg == CMD_READID && resultReady && idx_reg == 4'h3) |-> resultByte == id_reg.cylinder)
		else $error("read identifier cylinder byte wrong");
	chk_perp_update: assert property (@(posedge mclk) disable iff (!rst_n)
		(state_reg == ST_PARAM && kind_reg == CMD_PERP && clkEn && cmdWrite && !softReset)
		|=> perpOut.write_gate_timing == $past(cmdByte[0]) && perpOut.gap == $past(cmdByte[1]))
		else $error("perpendicular byte not stored");
	chk_invalid_answer: assert property (@(posedge mclk) disable iff (!rst_n)
		(resultReady && kind_reg == CMD_INVALID) |-> (resultByte == 8'h80 && standby))
		else $error("invalid code answer wrong");
	chk_lock_answer: assert property (@(posedge mclk) disable iff (!rst_n)
		(resultReady && kind_reg == CMD_LOCK) |-> resultByte == {3'b000, retentionFlag, 4'h0})
		else $error("lock answer wrong");
	chk_drive_pins: assert property (@(posedge mclk) disable iff (!rst_n)
		clkEn |=> driveSelectPin == $past(digital_output_register_drive))
		else $error("drive select pins not following output register");
	chk_lock_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
		(clkEn && softReset && retentionFlag && !cfgLoad && state_reg == ST_IDLE)
		|=> (cfgOut == $past(cfgOut) && perpOut == $past(perpOut)))
		else $error("locked settings lost on soft reset");

endmodule : floppy_command_subset_decoder

/* File: floppy_host_model.sv */
// Host-side driver model that writes command bytes and reads result bytes.
module floppy_host_model (
	input wire logic mclk,
	input wire logic resultReady,
	input wire logic [7:0] resultByte,
	output logic cmdWrite,
	output logic [7:0] cmdByte,
	output logic resultRead,
	output logic [1:0] digital_output_register_drive
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle values at time zero, before any request.
	initial begin
		cmdWrite = 1'b0;
		cmdByte = 8'h00;
		resultRead = 1'b0;
		digital_output_register_drive = 2'h0;
	end

	// One byte per strobe; the released bus shows the inverse so a stale byte never passes.
	task automatic sendByte(input logic [7:0] b);
		@(negedge mclk);
		cmdWrite = 1'b1;
		cmdByte = b;
		@(negedge mclk);
		cmdWrite = 1'b0;
		cmdByte = ~b;
	endtask : sendByte

	// Waits a bounded time for a result byte, takes it and acknowledges it for one edge.
	task automatic readByte(output logic [7:0] b, output logic ok);
		ok = 1'b0;
		b = 8'h00;
		// Let one edge pass so back to back reads never retoggle the strobe in one step.
		@(negedge mclk);
		for (int i = 0; i < 64 && !ok; i++) begin
			if (resultReady === 1'b1) ok = 1'b1;
			else @(negedge mclk);
		end
		if (ok) begin
			b = resultByte;
			resultRead = 1'b1;
			@(negedge mclk);
			resultRead = 1'b0;
		end
	endtask : readByte

	// The host selects the drive through the output register before naming it in a command.
	task automatic selectDrive(input logic [1:0] d);
		@(negedge mclk);
		digital_output_register_drive = d;
	endtask : selectDrive
endmodule : floppy_host_model

/* File: testbench.sv */
// Self-checking testbench for the floppy command subset decoder.
module testbench import floppy_cmd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	// -------------------------------------------------------------------------
	// Stimulus and observed signals
	// -------------------------------------------------------------------------
	logic mclk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, softReset = 1'b0, cfgLoad = 1'b0;
	logic lastWasFormat = 1'b0, idFound = 1'b0, cmdWrite, resultRead;
	logic [7:0] cmdByte, resultByte, handOffOpcode, spc = 8'h12, fsn = 8'h34;
	logic [3:0][7:0] presentCyl = {8'h44, 8'h33, 8'h22, 8'h11};
	logic [1:0] digital_output_register, cmdDrive, driveSelectPin;
	logic resultReady, busy, readIdStart, ddSel, headSel, standby, handOff, retentionFlag;
	config_t cfgIn = 15'h0000, cfgOut, expCfg = 15'h2000;
	specify_t specIn = 16'ha5c3;
	id_result_t idIn = 56'h0;
	perp_t perpOut, expPerp = 6'h00;
	logic expLock = 1'b0;
	int failCount = 0, cmpCount = 0;

	// A half period of 2.5 ns gives the 200 MHz controller clock.
	always #2.5 mclk = ~mclk;

	floppy_command_subset_decoder floppy_command_subset_decoder_inst (.mclk(mclk),
		.rst_n(rst_n), .clkEn(clkEn), .cmdWrite(cmdWrite), .cmdByte(cmdByte),
		.resultRead(resultRead), .softReset(softReset), .cfgLoad(cfgLoad), .cfgIn(cfgIn),
		.specIn(specIn), .present_cylinder_number(presentCyl), .lastWasFormat(lastWasFormat),
		.sectors_per_cylinder(spc), .final_sector_number(fsn), .idFound(idFound), .idIn(idIn),
		.digital_output_register_drive(digital_output_register), .resultReady(resultReady),
		.resultByte(resultByte), .busy(busy), .readIdStart(readIdStart),
		.double_density_select(ddSel), .head_select(headSel), .cmdDrive(cmdDrive),
		.standby(standby), .handOff(handOff), .handOffOpcode(handOffOpcode),
		.retentionFlag(retentionFlag), .perpOut(perpOut), .cfgOut(cfgOut),
		.driveSelectPin(driveSelectPin));

	floppy_host_model floppy_host_model_inst (.mclk(mclk), .resultReady(resultReady),
		.resultByte(resultByte), .cmdWrite(cmdWrite), .cmdByte(cmdByte),
		.resultRead(resultRead), .digital_output_register_drive(digital_output_register));

	// -------------------------------------------------------------------------
	// Shared helpers
	// -------------------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			failCount++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Reads one result byte and compares it; a missing byte is a mismatch too.
	task automatic getByte(input string what, input logic [7:0] exp);
		logic [7:0] b;
		logic ok;
		floppy_host_model_inst.readByte(b, ok);
		check({what, " present"}, ok, 1'b1);
		check(what, b, exp);
	endtask : getByte

	// Pulses soft reset or a configuration load for one enabled edge.
	task automatic pulseCtl(input logic sr, input logic ld, input config_t v);
		@(negedge mclk);
		softReset = sr;
		cfgLoad = ld;
		cfgIn = v;
		@(negedge mclk);
		softReset = 1'b0;
		cfgLoad = 1'b0;
		cfgIn = ~v;
	endtask : pulseCtl

	task automatic perpTest(input logic [7:0] p, input perp_t exp);
		floppy_host_model_inst.sendByte(8'h12);
		floppy_host_model_inst.sendByte(p);
		repeat (2) @(negedge mclk);
		check("perpOut", perpOut, exp);
		check("perp busy", busy, 1'b0);
		expPerp = exp;
	endtask : perpTest

	// A write during the result phase must be dropped, so a lock opcode is tried mid-dump.
	task automatic dumpTest(input logic fmt);
		logic [7:0] e [10];
		@(negedge mclk);
		lastWasFormat = fmt;
		for (int i = 0; i < 4; i++) e[i] = presentCyl[i];
		e[4] = specIn[15:8];
		e[5] = specIn[7:0];
		e[6] = fmt ? spc : fsn;
		e[7] = {expLock, 1'b0, expPerp};
		e[8] = {1'b0, expCfg[14:8]};
		e[9] = expCfg[7:0];
		floppy_host_model_inst.sendByte(8'h0e);
		for (int i = 0; i < 10; i++) begin
			getByte($sformatf("dump byte %0d", i), e[i]);
			if (i == 2) floppy_host_model_inst.sendByte(8'h94);
		end
		check("dump end", resultReady, 1'b0);
		check("dropped lock", retentionFlag, expLock);
	endtask : dumpTest

	task automatic ridTest(input logic [7:0] op, input logic [1:0] drv, input id_result_t v);
		logic seen;
		seen = 1'b0;
		floppy_host_model_inst.selectDrive(drv);
		floppy_host_model_inst.sendByte(op);
		floppy_host_model_inst.sendByte(8'h06);
		for (int i = 0; i < 4 && !seen; i++) begin
			if (readIdStart === 1'b1) seen = 1'b1;
			else @(negedge mclk);
		end
		check("readIdStart", seen, 1'b1);
		check("density", ddSel, op[6]);
		check("head", headSel, 1'b1);
		check("cmdDrive", cmdDrive, 2'h2);
		check("drive pins", driveSelectPin, drv);
		@(negedge mclk);
		idIn = v;
		idFound = 1'b1;
		@(negedge mclk);
		idFound = 1'b0;
		idIn = ~v;
		for (int i = 0; i < 7; i++) getByte("read id byte", v[55 - 8 * i -: 8]);
	endtask : ridTest

	task automatic lockTest(input logic [7:0] op);
		expLock = op[7];
		floppy_host_model_inst.sendByte(op);
		check("standby cleared", standby, 1'b0);
		getByte("lock answer", {3'h0, expLock, 4'h0});
		check("retentionFlag", retentionFlag, expLock);
		pulseCtl(1'b1, 1'b0, 15'h0000);
		if (!expLock) begin
			expCfg = 15'h2000;
			expPerp = 6'h00;
		end
		check("cfg after soft reset", cfgOut, expCfg);
		check("perp after soft reset", perpOut, expPerp);
	endtask : lockTest

	// A code owned by another handler is passed on for one cycle and gets no answer here.
	task automatic handOffTest(input logic [7:0] op);
		floppy_host_model_inst.sendByte(op);
		check("handOff", handOff, 1'b1);
		check("handOffOpcode", handOffOpcode, op);
		check("handOff standby", standby, 1'b0);
		@(negedge mclk);
		check("handOff pulse", handOff, 1'b0);
		check("handOff ready", resultReady, 1'b0);
		check("handOff busy", busy, 1'b0);
	endtask : handOffTest

	// With the clock enable low a dump opcode must leave no trace at all.
	task automatic freezeTest();
		@(negedge mclk);
		clkEn = 1'b0;
		floppy_host_model_inst.sendByte(8'h0e);
		@(negedge mclk);
		clkEn = 1'b1;
		check("frozen busy", busy, 1'b0);
		check("frozen ready", resultReady, 1'b0);
	endtask : freezeTest

	task automatic wrapUp();
		if (failCount == 0 && cmpCount > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrapUp

	// -------------------------------------------------------------------------
	// Main sequence and watchdog
	// -------------------------------------------------------------------------
	initial begin
		logic [7:0] bad [10];
		bad = '{8'h00, 8'h01, 8'h0b, 8'h15, 8'h17, 8'h1a, 8'h1b, 8'h1c, 8'h1e, 8'h1f};
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		check("cfg reset", cfgOut, 15'h2000);
		check("idle ready", resultReady, 1'b0);
		perpTest(8'haa, 6'b101010);
		perpTest(8'h15, 6'b101001);
		pulseCtl(1'b0, 1'b1, 15'h3b7e);
		expCfg = 15'h3b7e;
		dumpTest(1'b1);
		dumpTest(1'b0);
		ridTest(8'h4a, 2'h1, 56'h40_01_02_05_01_07_02);
		ridTest(8'h0a, 2'h2, 56'h00_00_00_27_00_0c_03);
		foreach (bad[i]) begin
			floppy_host_model_inst.sendByte(bad[i]);
			check("standby", standby, 1'b1);
			getByte("invalid answer", 8'h80);
			check("single byte", resultReady, 1'b0);
		end
		handOffTest(8'h03);
		handOffTest(8'h8f);
		freezeTest();
		lockTest(8'h94);
		dumpTest(1'b0);
		lockTest(8'h14);
		wrapUp();
	end

	// The whole sequence takes a few hundred cycles; twenty thousand means a hang.
	initial begin
		#100000;
		failCount++;
		wrapUp();
	end
endmodule : testbench
